// File: rtl/dram_command_spacing_tracker.sv
// Command spacing tracker for one DDR channel with its spacing registers
`timescale 1ns/1ps
module dram_command_spacing_tracker #(
   parameter int RANKS = 4,
   parameter int BANKS = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [spacing_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic cmd_valid,
   input wire spacing_pkg::cmd_t cmd_kind,
   input wire logic [$clog2(RANKS)-1:0] cmd_rank,
   input wire logic [$clog2(BANKS)-1:0] cmd_bank,
   output logic cmd_ready,
   output logic cmd_issue,
   output logic [RANKS-1:0] window_blocked
);
   import spacing_pkg::*;

   localparam int RANK_W = $clog2(RANKS);
   localparam int EW = ELAPSED_W;

   typedef struct packed {
      logic [15:0] pre_cfg;
      logic [31:0] act_cfg;
      logic [15:0] wr_cfg;
      logic [31:0] rdata;
      logic [RANKS-1:0][BANKS-1:0][EW-1:0] act_bk;
      logic [RANKS-1:0][BANKS-1:0][EW-1:0] wr_bk;
      logic [RANKS-1:0][BANKS-1:0][EW-1:0] rd_bk;
      logic [RANKS-1:0][BANKS-1:0][EW-1:0] pre_bk;
      logic [RANKS-1:0][EW-1:0] act_rk;
      logic [RANKS-1:0][EW-1:0] pre_rk;
      logic [RANKS-1:0][EW-1:0] ref_rk;
      logic [RANKS-1:0][EW-1:0] wr_rk;
      logic [EW-1:0] preall;
      logic [EW-1:0] wr_any;
      logic [EW-1:0] rd_any;
      logic [RANK_W-1:0] last_wr_rank;
   } track_state_t;

   // Counters come out of reset expired so nothing is held
   localparam track_state_t STATE_RST = '{
      pre_cfg: PRECHARGE_SPACING_RST,
      act_cfg: ACTIVATE_SPACING_RST,
      wr_cfg: WRITE_SPACING_RST,
      rdata: '0,
      act_bk: '1,
      wr_bk: '1,
      rd_bk: '1,
      pre_bk: '1,
      act_rk: '1,
      pre_rk: '1,
      ref_rk: '1,
      wr_rk: '1,
      preall: '1,
      wr_any: '1,
      rd_any: '1,
      last_wr_rank: '0
   };

   track_state_t s_r;
   track_state_t s_nxt;
   logic cmd_ok;

   logic [EW-1:0] act_to_pre_gap;
   logic [EW-1:0] write_to_pre_gap;
   logic [EW-1:0] read_to_pre_gap;
   logic [EW-1:0] pre_to_pre_gap;
   logic [WINDOW_LEN_W-1:0] activate_window_length;
   logic activate_limit_disable;
   logic [EW-1:0] act_to_act_gap;
   logic [EW-1:0] pre_to_act_gap;
   logic [EW-1:0] preall_to_act_gap;
   logic [EW-1:0] refresh_to_act_gap;
   logic [EW-1:0] act_to_write_gap;
   logic [EW-1:0] same_rank_write_gap;
   logic [EW-1:0] cross_rank_write_gap;
   logic [EW-1:0] read_to_write_gap;

   // Field extraction
   assign act_to_pre_gap = EW'(s_r.pre_cfg[ACT_TO_PRE_LSB +: ACT_TO_PRE_W]);
   assign write_to_pre_gap = EW'(s_r.pre_cfg[WRITE_TO_PRE_LSB +: WRITE_TO_PRE_W]);
   assign read_to_pre_gap = EW'(s_r.pre_cfg[READ_TO_PRE_LSB +: READ_TO_PRE_W]);
   assign pre_to_pre_gap = EW'(s_r.pre_cfg[PRE_TO_PRE_LSB +: PRE_TO_PRE_W]);
   assign activate_window_length = s_r.act_cfg[WINDOW_LEN_LSB +: WINDOW_LEN_W];
   assign activate_limit_disable = s_r.act_cfg[LIMIT_DISABLE_BIT];
   assign act_to_act_gap = EW'(s_r.act_cfg[ACT_TO_ACT_LSB +: ACT_TO_ACT_W]);
   assign pre_to_act_gap = EW'(s_r.act_cfg[PRE_TO_ACT_LSB +: PRE_TO_ACT_W]);
   assign preall_to_act_gap = EW'(s_r.act_cfg[PREALL_TO_ACT_LSB +: PREALL_TO_ACT_W]);
   assign refresh_to_act_gap = EW'(s_r.act_cfg[REFRESH_TO_ACT_LSB +: REFRESH_TO_ACT_W]);
   assign act_to_write_gap = EW'(s_r.wr_cfg[ACT_TO_WRITE_LSB +: ACT_TO_WRITE_W]);
   assign same_rank_write_gap = EW'(s_r.wr_cfg[SAME_RANK_WRITE_LSB +: SAME_RANK_WRITE_W]);
   assign cross_rank_write_gap = EW'(s_r.wr_cfg[CROSS_RANK_WRITE_LSB +: CROSS_RANK_WRITE_W]);
   assign read_to_write_gap = EW'(s_r.wr_cfg[READ_TO_WRITE_LSB +: READ_TO_WRITE_W]);

   // Per-rank activate windows
   genvar gr;
   generate
      for (gr = 0; gr < RANKS; gr++) begin : g_window
         activate_window u_window (
            .mclk(mclk),
            .rst_n(rst_n),
            .ce(ce),
            .act_issue(cmd_issue && cmd_kind == CMD_ACT && cmd_rank == RANK_W'(gr)),
            .window_length(activate_window_length),
            .limit_disable(activate_limit_disable),
            .blocked(window_blocked[gr])
         );
      end
   endgenerate

   assign cmd_ready = cmd_ok;
   assign cmd_issue = cmd_valid && cmd_ok && ce;
   assign reg_rdata = s_r.rdata;

   always_comb begin
      s_nxt = s_r;
      cmd_ok = 1'b0;

      // Elapsed counters saturate so an old command never blocks
      for (int r = 0; r < RANKS; r++) begin
         for (int b = 0; b < BANKS; b++) begin
            if (s_r.act_bk[r][b] != '1) s_nxt.act_bk[r][b] = s_r.act_bk[r][b] + 1'b1;
            if (s_r.wr_bk[r][b] != '1) s_nxt.wr_bk[r][b] = s_r.wr_bk[r][b] + 1'b1;
            if (s_r.rd_bk[r][b] != '1) s_nxt.rd_bk[r][b] = s_r.rd_bk[r][b] + 1'b1;
            if (s_r.pre_bk[r][b] != '1) s_nxt.pre_bk[r][b] = s_r.pre_bk[r][b] + 1'b1;
         end
         if (s_r.act_rk[r] != '1) s_nxt.act_rk[r] = s_r.act_rk[r] + 1'b1;
         if (s_r.pre_rk[r] != '1) s_nxt.pre_rk[r] = s_r.pre_rk[r] + 1'b1;
         if (s_r.ref_rk[r] != '1) s_nxt.ref_rk[r] = s_r.ref_rk[r] + 1'b1;
         if (s_r.wr_rk[r] != '1) s_nxt.wr_rk[r] = s_r.wr_rk[r] + 1'b1;
      end
      if (s_r.preall != '1) s_nxt.preall = s_r.preall + 1'b1;
      if (s_r.wr_any != '1) s_nxt.wr_any = s_r.wr_any + 1'b1;
      if (s_r.rd_any != '1) s_nxt.rd_any = s_r.rd_any + 1'b1;

      // Spacing checks for the offered command
      case (cmd_kind)
         CMD_ACT: begin
            cmd_ok = s_r.act_rk[cmd_rank] >= act_to_act_gap
               && s_r.pre_bk[cmd_rank][cmd_bank] >= pre_to_act_gap
               && s_r.preall >= preall_to_act_gap
               && s_r.ref_rk[cmd_rank] >= refresh_to_act_gap
               && !window_blocked[cmd_rank];
         end
         CMD_PRE: begin
            cmd_ok = s_r.act_bk[cmd_rank][cmd_bank] >= act_to_pre_gap
               && s_r.wr_bk[cmd_rank][cmd_bank] >= write_to_pre_gap
               && s_r.rd_bk[cmd_rank][cmd_bank] >= read_to_pre_gap
               && s_r.pre_rk[cmd_rank] >= pre_to_pre_gap;
         end
         CMD_PREALL: begin
            cmd_ok = s_r.pre_rk[cmd_rank] >= pre_to_pre_gap;
            for (int b = 0; b < BANKS; b++) begin
               if (s_r.act_bk[cmd_rank][b] < act_to_pre_gap) cmd_ok = 1'b0;
               if (s_r.wr_bk[cmd_rank][b] < write_to_pre_gap) cmd_ok = 1'b0;
               if (s_r.rd_bk[cmd_rank][b] < read_to_pre_gap) cmd_ok = 1'b0;
            end
         end
         CMD_WR: begin
            cmd_ok = s_r.act_bk[cmd_rank][cmd_bank] >= act_to_write_gap
               && s_r.wr_rk[cmd_rank] >= same_rank_write_gap
               && (s_r.last_wr_rank == cmd_rank
                  || s_r.wr_any >= cross_rank_write_gap)
               && s_r.rd_any >= read_to_write_gap;
         end
         CMD_REF, CMD_RD, CMD_NOP: begin
            cmd_ok = 1'b1;
         end
         default: begin
            cmd_ok = 1'b0;
         end
      endcase

      // Restart counters at launch; the flops only load while ce is high
      if (cmd_valid && cmd_ok) begin
         case (cmd_kind)
            CMD_ACT: begin
               s_nxt.act_bk[cmd_rank][cmd_bank] = ELAPSED_START;
               s_nxt.act_rk[cmd_rank] = ELAPSED_START;
            end
            CMD_PRE: begin
               s_nxt.pre_bk[cmd_rank][cmd_bank] = ELAPSED_START;
               s_nxt.pre_rk[cmd_rank] = ELAPSED_START;
            end
            CMD_PREALL: begin
               for (int b = 0; b < BANKS; b++) s_nxt.pre_bk[cmd_rank][b] = ELAPSED_START;
               s_nxt.pre_rk[cmd_rank] = ELAPSED_START;
               s_nxt.preall = ELAPSED_START;
            end
            CMD_REF: begin
               s_nxt.ref_rk[cmd_rank] = ELAPSED_START;
            end
            CMD_RD: begin
               s_nxt.rd_bk[cmd_rank][cmd_bank] = ELAPSED_START;
               s_nxt.rd_any = ELAPSED_START;
            end
            CMD_WR: begin
               s_nxt.wr_bk[cmd_rank][cmd_bank] = ELAPSED_START;
               s_nxt.wr_rk[cmd_rank] = ELAPSED_START;
               s_nxt.wr_any = ELAPSED_START;
               s_nxt.last_wr_rank = cmd_rank;
            end
            default: begin
            end
         endcase
      end

      // Register writes at their offsets
      if (reg_wr) begin
         case (reg_addr)
            PRECHARGE_SPACING_OFS: s_nxt.pre_cfg = reg_wdata[15:0];
            ACTIVATE_SPACING_OFS: s_nxt.act_cfg = reg_wdata & ACTIVATE_SPACING_RW_MASK;
            WRITE_SPACING_OFS: s_nxt.wr_cfg = reg_wdata[15:0];
            default: s_nxt.wr_cfg = s_r.wr_cfg;
         endcase
      end

      // Register reads, one cycle latency
      if (reg_rd) begin
         case (reg_addr)
            PRECHARGE_SPACING_OFS: s_nxt.rdata = {16'h0000, s_r.pre_cfg};
            ACTIVATE_SPACING_OFS: s_nxt.rdata = s_r.act_cfg;
            WRITE_SPACING_OFS: s_nxt.rdata = {16'h0000, s_r.wr_cfg};
            default: s_nxt.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_r <= STATE_RST;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_act_pre_gap: assert property (cmd_issue && cmd_kind == CMD_PRE
      |-> s_r.act_bk[cmd_rank][cmd_bank] >= act_to_pre_gap)
      else $error("precharge too soon after activate");
   a_write_recovery: assert property (cmd_issue && cmd_kind == CMD_PRE
      |-> s_r.wr_bk[cmd_rank][cmd_bank] >= write_to_pre_gap)
      else $error("precharge too soon after write");
   a_read_pre_gap: assert property (cmd_issue && cmd_kind == CMD_PRE
      |-> s_r.rd_bk[cmd_rank][cmd_bank] >= read_to_pre_gap)
      else $error("precharge too soon after read");
   a_pre_pre_gap: assert property (cmd_issue && (cmd_kind == CMD_PRE || cmd_kind == CMD_PREALL)
      |-> s_r.pre_rk[cmd_rank] >= pre_to_pre_gap)
      else $error("precharges to one rank too close");
   a_window_start: assert property (cmd_issue && cmd_kind == CMD_ACT && cmd_rank == '0
      && !g_window[0].u_window.s_r.active |=> g_window[0].u_window.s_r.active)
      else $error("activate did not open a window");
   a_window_hold: assert property (cmd_issue && cmd_kind == CMD_ACT
      |-> !window_blocked[cmd_rank])
      else $error("activate issued into a full window");
   a_limit_disable: assert property (activate_limit_disable |-> window_blocked == '0)
      else $error("window blocks while the limit is disabled");
   a_act_act_gap: assert property (cmd_issue && cmd_kind == CMD_ACT
      |-> s_r.act_rk[cmd_rank] >= act_to_act_gap)
      else $error("activates to one rank too close");
   a_pre_act_gap: assert property (cmd_issue && cmd_kind == CMD_ACT
      |-> s_r.pre_bk[cmd_rank][cmd_bank] >= pre_to_act_gap)
      else $error("activate too soon after precharge");
   a_preall_act: assert property (cmd_issue && cmd_kind == CMD_ACT
      |-> s_r.preall >= preall_to_act_gap)
      else $error("activate too soon after precharge-all");
   a_refresh_act: assert property (cmd_issue && cmd_kind == CMD_ACT
      |-> s_r.ref_rk[cmd_rank] >= refresh_to_act_gap)
      else $error("activate too soon after refresh");
   a_act_write_gap: assert property (cmd_issue && cmd_kind == CMD_WR
      |-> s_r.act_bk[cmd_rank][cmd_bank] >= act_to_write_gap)
      else $error("write too soon after activate");
   a_same_rank_wr: assert property (cmd_issue && cmd_kind == CMD_WR
      |-> s_r.wr_rk[cmd_rank] >= same_rank_write_gap)
      else $error("writes to one rank too close");
   a_cross_rank_wr: assert property (cmd_issue && cmd_kind == CMD_WR
      && cmd_rank != s_r.last_wr_rank |-> s_r.wr_any >= cross_rank_write_gap)
      else $error("writes to different ranks too close");
   a_read_write_gap: assert property (cmd_issue && cmd_kind == CMD_WR
      |-> s_r.rd_any >= read_to_write_gap)
      else $error("write too soon after read");
   a_counter_start: assert property (cmd_issue && cmd_kind == CMD_ACT
      |=> s_r.act_rk[$past(cmd_rank)] == ELAPSED_START)
      else $error("activate counter did not restart");

   c_act_issue: cover property (cmd_issue && cmd_kind == CMD_ACT);
   c_cross_write: cover property (cmd_issue && cmd_kind == CMD_WR && cmd_rank != s_r.last_wr_rank);
   c_window_full: cover property (cmd_valid && cmd_kind == CMD_ACT && window_blocked[cmd_rank]);
   c_preall: cover property (cmd_issue && cmd_kind == CMD_PREALL);

endmodule : dram_command_spacing_tracker

// File: rtl/spacing_pkg.sv
// Constants, register map and command codes for the command spacing tracker
package spacing_pkg;

   localparam int ELAPSED_W = 9;
   localparam logic [ELAPSED_W-1:0] ELAPSED_START = 9'h001;

   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] PRECHARGE_SPACING_OFS = 12'h650;
   localparam logic [ADDR_W-1:0] ACTIVATE_SPACING_OFS = 12'h652;
   localparam logic [ADDR_W-1:0] WRITE_SPACING_OFS = 12'h656;

   localparam logic [15:0] PRECHARGE_SPACING_RST = 16'h0000;
   localparam logic [31:0] ACTIVATE_SPACING_RST = 32'h00000000;
   localparam logic [15:0] WRITE_SPACING_RST = 16'h0000;
   localparam logic [31:0] ACTIVATE_SPACING_RW_MASK = 32'h0FFFFFFF;

   // Precharge spacing fields
   localparam int ACT_TO_PRE_LSB = 11;
   localparam int ACT_TO_PRE_W = 5;
   localparam int WRITE_TO_PRE_LSB = 6;
   localparam int WRITE_TO_PRE_W = 5;
   localparam int READ_TO_PRE_LSB = 2;
   localparam int READ_TO_PRE_W = 4;
   localparam int PRE_TO_PRE_LSB = 0;
   localparam int PRE_TO_PRE_W = 2;

   // Activate spacing fields
   localparam int WINDOW_LEN_LSB = 22;
   localparam int WINDOW_LEN_W = 6;
   localparam int LIMIT_DISABLE_BIT = 21;
   localparam int ACT_TO_ACT_LSB = 17;
   localparam int ACT_TO_ACT_W = 4;
   localparam int PRE_TO_ACT_LSB = 13;
   localparam int PRE_TO_ACT_W = 4;
   localparam int PREALL_TO_ACT_LSB = 9;
   localparam int PREALL_TO_ACT_W = 4;
   localparam int REFRESH_TO_ACT_LSB = 0;
   localparam int REFRESH_TO_ACT_W = 9;

   // Write spacing fields
   localparam int ACT_TO_WRITE_LSB = 12;
   localparam int ACT_TO_WRITE_W = 4;
   localparam int SAME_RANK_WRITE_LSB = 8;
   localparam int SAME_RANK_WRITE_W = 4;
   localparam int CROSS_RANK_WRITE_LSB = 4;
   localparam int CROSS_RANK_WRITE_W = 4;
   localparam int READ_TO_WRITE_LSB = 0;
   localparam int READ_TO_WRITE_W = 4;

   // Activate window
   localparam int WINDOW_CNT_W = 3;
   localparam logic [WINDOW_CNT_W-1:0] ACTIVATE_LIMIT = 3'h4;

   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_ACT,
      CMD_PRE,
      CMD_PREALL,
      CMD_REF,
      CMD_RD,
      CMD_WR
   } cmd_t;

endpackage : spacing_pkg

// File: rtl/activate_window.sv
// Fixed activate window for one rank, opened by its first activate
`timescale 1ns/1ps
module activate_window (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic act_issue,
   input wire logic [spacing_pkg::WINDOW_LEN_W-1:0] window_length,
   input wire logic limit_disable,
   output logic blocked
);
   import spacing_pkg::*;

   typedef struct packed {
      logic active;
      logic [WINDOW_LEN_W-1:0] timer;
      logic [WINDOW_CNT_W-1:0] count;
   } win_state_t;

   win_state_t s_r;
   win_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (s_r.active && s_r.timer >= window_length) begin
         s_nxt.active = 1'b0;
         s_nxt.count = '0;
      end else if (s_r.active) begin
         s_nxt.timer = s_r.timer + 1'b1;
      end
      if (act_issue) begin
         if (!s_nxt.active) begin
            s_nxt.active = 1'b1;
            s_nxt.timer = {{(WINDOW_LEN_W-1){1'b0}}, 1'b1};
            s_nxt.count = {{(WINDOW_CNT_W-1){1'b0}}, 1'b1};
         end else if (s_r.count != ACTIVATE_LIMIT) begin
            s_nxt.count = s_r.count + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // Held until the window runs out; the disable bit lifts the hold
   assign blocked = s_r.active && (s_r.count >= ACTIVATE_LIMIT) && !limit_disable;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_window_closes: assert property ((ce && s_r.active && s_r.timer >= window_length)
      |=> !s_r.active || $past(act_issue))
      else $error("activate window did not close at its length");
   a_window_count_cap: assert property (s_r.count <= ACTIVATE_LIMIT)
      else $error("activate window count above limit");

endmodule : activate_window

// File: tb/dram_ranks_model.sv
// Memory rank model that checks launched activate and write spacing per rank
`timescale 1ns/1ps
module dram_ranks_model (
   input wire logic mclk,
   input wire logic issue,
   input wire spacing_pkg::cmd_t kind,
   input wire logic [1:0] rank,
   input wire logic [3:0] act_gap,
   input wire logic [3:0] wr_gap,
   output logic [15:0] violations
);
   import spacing_pkg::*;
   int now = 0;
   int viol_cnt = 0;
   int last_act[4] = '{default: -100};
   int last_wr[4] = '{default: -100};
   assign violations = 16'(viol_cnt);
   always @(posedge mclk) begin
      if (issue === 1'b1 && kind == CMD_ACT) begin
         if (now - last_act[rank] < int'(act_gap)) viol_cnt++;
         last_act[rank] = now;
      end
      if (issue === 1'b1 && kind == CMD_WR) begin
         if (now - last_wr[rank] < int'(wr_gap)) viol_cnt++;
         last_wr[rank] = now;
      end
      now++;
   end
endmodule : dram_ranks_model

// File: tb/dram_command_spacing_tracker_tb.sv
// Self-checking bench for the command spacing tracker
`timescale 1ns/1ps
module dram_command_spacing_tracker_tb;
   import spacing_pkg::*;
   logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cmd_valid = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   cmd_t cmd_kind = CMD_NOP;
   logic [1:0] cmd_rank = 2'h0;
   logic [2:0] cmd_bank = 3'h0;
   logic cmd_ready, cmd_issue, rd_pend = 1'b0;
   logic [3:0] window_blocked, act_gap = 4'h0;
   logic [15:0] violations;
   logic [7:0] lfsr_r = 8'h45;
   int cyc = 0, error_cnt = 0, n_compared = 0, lt, w0, g;
   int iss_q[$];
   logic [31:0] rd_q[$];
   always #50 mclk = ~mclk;
   dram_command_spacing_tracker u_dram_command_spacing_tracker (.mclk(mclk), .rst_n(rst_n),
      .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_rank(cmd_rank),
      .cmd_bank(cmd_bank), .cmd_ready(cmd_ready), .cmd_issue(cmd_issue),
      .window_blocked(window_blocked));
   dram_ranks_model u_dram_ranks_model (.mclk(mclk), .issue(cmd_issue), .kind(cmd_kind),
      .rank(cmd_rank), .act_gap(act_gap), .wr_gap(4'h4), .violations(violations));
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next
   task automatic complete_run();
      $display("Compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(negedge mclk);
      cmd_valid = 1'b0;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      rd_q.push_back(e);
      @(negedge mclk);
      reg_rd = 1'b0;
   endtask : rd
   // Offer a command; w is the expected wait in cycles, negative for none
   task automatic go(input cmd_t k, input logic [1:0] r, input logic [2:0] b, input int w,
      output int at);
      int n;
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_rank = r;
      cmd_bank = b;
      if (w >= 0) iss_q.push_back(cyc + w);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (cmd_issue !== 1'b1 && n < 60);
      at = cyc;
      if (cmd_issue !== 1'b1) check(32'h1, 32'h0);
   endtask : go
   // Result monitors
   always @(posedge mclk) begin
      if (cmd_issue === 1'b1 && iss_q.size() > 0) check(iss_q.pop_front(), cyc);
      rd_pend <= reg_rd & ce;
      cyc <= cyc + 1;
      if (cyc > 4000) begin
         error_cnt++;
         complete_run();
      end
   end
   always @(negedge mclk) begin
      if (rd_pend) check(rd_q.pop_front(), reg_rdata);
   end
   initial begin
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      rd(PRECHARGE_SPACING_OFS, 32'h0);
      rd(ACTIVATE_SPACING_OFS, 32'h0);
      rd(WRITE_SPACING_OFS, 32'h0);
      wr(ACTIVATE_SPACING_OFS, 32'hFFFFFFFF);
      rd(ACTIVATE_SPACING_OFS, 32'h0FFFFFFF);
      wr(PRECHARGE_SPACING_OFS, 32'hFFFFFFFF);
      rd(PRECHARGE_SPACING_OFS, 32'h0000FFFF);
      rd(12'h654, 32'h0);
      wr(PRECHARGE_SPACING_OFS, 32'h0000298E);
      wr(ACTIVATE_SPACING_OFS, 32'h05048607);
      wr(WRITE_SPACING_OFS, 32'h00003425);
      rd(WRITE_SPACING_OFS, 32'h00003425);
      act_gap = 4'h2;
      go(CMD_ACT, 2'h0, 3'h0, 0, lt);
      go(CMD_WR, 2'h0, 3'h0, 2, lt);
      go(CMD_WR, 2'h0, 3'h0, 3, lt);
      go(CMD_WR, 2'h1, 3'h0, 1, lt);
      go(CMD_RD, 2'h0, 3'h0, 0, lt);
      go(CMD_WR, 2'h2, 3'h0, 4, lt);
      go(CMD_RD, 2'h0, 3'h1, 0, lt);
      go(CMD_PRE, 2'h0, 3'h1, 2, lt);
      go(CMD_ACT, 2'h1, 3'h1, 0, lt);
      go(CMD_PRE, 2'h1, 3'h1, 4, lt);
      go(CMD_ACT, 2'h1, 3'h2, 0, lt);
      go(CMD_WR, 2'h1, 3'h2, 2, lt);
      go(CMD_PRE, 2'h1, 3'h2, 5, lt);
      go(CMD_PRE, 2'h1, 3'h3, 1, lt);
      go(CMD_ACT, 2'h1, 3'h3, 3, lt);
      go(CMD_ACT, 2'h1, 3'h4, 1, lt);
      go(CMD_PREALL, 2'h3, 3'h0, 0, lt);
      go(CMD_ACT, 2'h2, 3'h0, 2, lt);
      go(CMD_REF, 2'h0, 3'h0, 0, lt);
      go(CMD_ACT, 2'h0, 3'h5, 6, lt);
      go(CMD_ACT, 2'h3, 3'h0, 0, w0);
      for (int i = 1; i < 4; i++) go(CMD_ACT, 2'h3, 3'(i), 1, lt);
      @(negedge mclk);
      check(32'h1, {31'h0, window_blocked[3]});
      go(CMD_ACT, 2'h3, 3'h4, -1, lt);
      check(32'h1, 32'(lt >= w0 + 20 && lt <= w0 + 22));
      wr(ACTIVATE_SPACING_OFS, 32'h05248607);
      for (int i = 1; i < 6; i++) go(CMD_ACT, 2'h2, 3'(i), (i == 1) ? 0 : 1, lt);
      @(negedge mclk);
      check(32'h0, {31'h0, window_blocked[2]});
      for (int i = 0; i < 4; i++) begin
         lfsr_r = lfsr_next(lfsr_r);
         g = int'(lfsr_r[3:0]);
         wr(ACTIVATE_SPACING_OFS, (32'h05248607 & ~32'h001E0000) | (32'(g) << 17));
         act_gap = lfsr_r[3:0];
         repeat (16) @(negedge mclk);
         go(CMD_ACT, 2'h0, 3'h6, 0, lt);
         go(CMD_ACT, 2'h0, 3'h7, (g < 2) ? 0 : g - 1, lt);
      end
      // Clock enable low freezes the refresh counter for four cycles
      go(CMD_REF, 2'h1, 3'h0, 0, lt);
      @(negedge mclk);
      ce = 1'b0;
      cmd_kind = CMD_RD;
      @(negedge mclk);
      check(32'h1, {31'h0, cmd_ready});
      check(32'h0, {31'h0, cmd_issue});
      cmd_kind = CMD_ACT;
      cmd_bank = 3'h5;
      repeat (3) @(negedge mclk);
      check(32'h0, {31'h0, cmd_ready});
      ce = 1'b1;
      cmd_valid = 1'b0;
      go(CMD_ACT, 2'h1, 3'h5, 5, lt);
      @(negedge mclk);
      cmd_valid = 1'b0;
      check(32'h0, {16'h0, violations});
      complete_run();
   end
endmodule : dram_command_spacing_tracker_tb
